//--- hw/acs_pkg.sv
// Constants and types shared by the converter control block
// Notes on behaviour
// - Writing calibration start one begins calibration
// - Calibration start reads one while running
// - Hardware clears it once calibration ends
// - Factor applies until converter is powered off
// - Calibration reset bit clears stored factor
// - Enable low holds converter in reset
// - Enable low powers analog part down
// - Converter clock synchronous with bus clocks
// - Sixteen external plus two internal channels
// - Resolution selectable 12, 10, 8, 6 bits
// - Result stored right or left aligned
// - Oversampler: 16-bit result, ratio 2-256, shift 0-8
// - Start from software or hardware trigger
// - Interrupts at end of conversion, threshold event
// - Sequence holds up to sixteen channel entries
// - 4-bit length field, three sequence registers
// - Result stored, end flag set, zero clears
`default_nettype none
package acs_pkg;
  localparam int AXI_AW     = 8;
  localparam int RAW_W      = 12;
  localparam int DATA_W     = 16;
  localparam int CH_W       = 5;
  localparam int SEQ_N      = 16;
  localparam int LEN_W      = 4;
  localparam int CF_W       = 7;
  localparam int ACC_W      = 20;
  localparam int CNT_W      = 9;
  localparam int NUM_EXT_CH = 16;
  localparam int NUM_INT_CH = 2;
  localparam logic [CH_W-1:0] CH_LAST = 5'h11;
  localparam logic [AXI_AW-1:0] OFF_CTRL   = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_STAT   = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_SEQ1   = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_SEQ2   = 8'h0c;
  localparam logic [AXI_AW-1:0] OFF_SEQ3   = 8'h10;
  localparam logic [AXI_AW-1:0] OFF_DATA   = 8'h14;
  localparam logic [AXI_AW-1:0] OFF_THR    = 8'h18;
  localparam logic [AXI_AW-1:0] OFF_OVS    = 8'h1c;
  localparam int CB_EN = 0, CB_CAL = 1, CB_CALRST = 2, CB_SWST = 3;
  localparam int CB_SCAN = 4, CB_CONT = 5, CB_LEFT = 6, CB_RES = 7;
  localparam int CB_HWTRIG = 9, CB_EOCIE = 10, CB_WDIE = 11, CB_WDEN = 12;
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_MASK = 13'h1ff1;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 13'h0000;
  localparam int SB_EOC = 0, SB_WD = 1, SB_BUSY = 2;
  localparam int LEN_LSB = 20, FIRST_W = 24, SECOND_W = 30, THIRD_W = 30;
  localparam int THR_HI_LSB = 16;
  localparam logic [RAW_W-1:0] THR_HI_RST = 12'hfff;
  localparam logic [RAW_W-1:0] THR_LO_RST = 12'h000;
  localparam int OB_EN = 0, OB_RATIO = 1, OB_SHIFT = 4, OVS_W = 8;
  localparam logic [3:0] SHIFT_MAX = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_NEXT} acs_seq_t;
  typedef enum logic {CAL_IDLE, CAL_RUN} acs_cal_t;

  function automatic logic [4:0] res_bits(input logic [1:0] code);
    case (code)
      2'h0:    res_bits = 5'h0c;
      2'h1:    res_bits = 5'h0a;
      2'h2:    res_bits = 5'h08;
      default: res_bits = 5'h06;
    endcase
  endfunction : res_bits

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge
endpackage : acs_pkg
`default_nettype wire

//--- hw/acs_cal.sv
// Foreground calibration sequencer and stored factor
`timescale 1ns/1ps
`default_nettype none
module acs_cal (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    enable,
  input  wire logic                    start,
  input  wire logic                    cal_reset,
  input  wire logic                    cal_done,
  input  wire logic [acs_pkg::CF_W-1:0] cal_factor_in,
  output logic                         busy,
  output logic [acs_pkg::CF_W-1:0]     factor
);
  import acs_pkg::*;

  acs_cal_t state;

  wire go = enable & start & (state == CAL_IDLE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state  <= CAL_IDLE;
      busy   <= 1'b0;
      factor <= '0;
    end else if (!enable) begin
      // Power-off loses the factor, so a fresh enable needs a new run
      state  <= CAL_IDLE;
      busy   <= 1'b0;
      factor <= '0;
    end else begin
      if (cal_reset) begin
        factor <= '0;
      end
      case (state)
        CAL_IDLE: begin
          if (go) begin
            state <= CAL_RUN;
            busy  <= 1'b1;
          end
        end
        CAL_RUN: begin
          // Only completion or a disable ends the run; other software writes have no say here
          if (cal_done) begin
            state  <= CAL_IDLE;
            busy   <= 1'b0;
            factor <= cal_factor_in;
          end
        end
        default: begin
          state <= CAL_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end
endmodule : acs_cal
`default_nettype wire

//--- hw/acs_ovs.sv
// Resolution, alignment and oversampling of converter results
`timescale 1ns/1ps
`default_nettype none
module acs_ovs (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       clear,
  input  wire logic                       in_valid,
  input  wire logic [acs_pkg::RAW_W-1:0]  in_raw,
  input  wire logic [1:0]                 res_code,
  input  wire logic                       left,
  input  wire logic                       ovs_en,
  input  wire logic [2:0]                 ratio,
  input  wire logic [3:0]                 shift,
  output logic                            out_valid,
  output logic [acs_pkg::DATA_W-1:0]      out_data,
  output logic [acs_pkg::RAW_W-1:0]       out_raw
);
  import acs_pkg::*;

  logic [ACC_W-1:0] acc;
  logic [CNT_W-1:0] cnt;

  wire [4:0]        rbits  = res_bits(res_code);
  wire [RAW_W-1:0]  value  = in_raw >> (5'(RAW_W) - rbits);
  wire [DATA_W-1:0] rjust  = DATA_W'(value);
  wire [DATA_W-1:0] ljust  = rjust << (5'(DATA_W) - rbits);
  wire [CNT_W-1:0]  target = CNT_W'(2) << ratio;
  wire [ACC_W-1:0]  sum    = acc + ACC_W'(value);
  wire [3:0]        sh     = (shift > SHIFT_MAX) ? SHIFT_MAX : shift;
  wire              last   = (cnt + 9'h001) == target;
  wire [ACC_W-1:0]  scaled = sum >> sh;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc       <= '0;
      cnt       <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
      out_raw   <= '0;
    end else if (clear) begin
      acc       <= '0;
      cnt       <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid & (~ovs_en | last);
      if (in_valid) begin
        out_raw <= in_raw;
        if (!ovs_en) begin
          out_data <= left ? ljust : rjust;
        end else if (last) begin
          // Oversampled words are always right aligned, 16 bits wide
          out_data <= scaled[DATA_W-1:0];
          acc      <= '0;
          cnt      <= '0;
        end else begin
          acc <= sum;
          cnt <= cnt + 9'h001;
        end
      end
    end
  end
endmodule : acs_ovs
`default_nettype wire

//--- hw/acs_top.sv
// Converter control block: AXI4-Lite registers, calibration and routine sequence
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module acs_top (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [acs_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [acs_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        hw_trigger,
  input  wire logic                        ana_done,
  input  wire logic [acs_pkg::RAW_W-1:0]   ana_data,
  input  wire logic                        ana_cal_done,
  input  wire logic [acs_pkg::CF_W-1:0]    ana_cal_factor,
  output logic                             ana_reset,
  output logic                             ana_powerdown,
  output logic                             ana_sample,
  output logic [acs_pkg::CH_W-1:0]         ana_chan,
  output logic [1:0]                       ana_res,
  output logic                             ana_cal_req,
  output logic [acs_pkg::CF_W-1:0]         cal_factor,
  output logic                             eoc_irq,
  output logic                             wd_irq
);
  import acs_pkg::*;

  // Software-visible state
  logic [CTRL_W-1:0]    ctrl;
  logic [FIRST_W-1:0]   seq_first;
  logic [SECOND_W-1:0]  seq_second;
  logic [THIRD_W-1:0]   seq_third;
  logic [RAW_W-1:0]     thr_hi;
  logic [RAW_W-1:0]     thr_lo;
  logic [OVS_W-1:0]     ovs_cfg;
  logic [DATA_W-1:0]    result;
  logic                 eoc;
  logic                 wd_flag;

  // Command pulses and trigger history
  logic                 swst_p;
  logic                 calst_p;
  logic                 calrst_p;
  logic                 trig_q;

  // Sequencer
  acs_seq_t             state;
  acs_seq_t             next_state;
  logic [LEN_W-1:0]     pos;
  logic [LEN_W-1:0]     next_pos;
  logic                 next_sample;
  logic [CH_W-1:0]      next_chan;
  logic                 store;
  logic                 eoc_set;

  // Sub-block results
  logic                 cal_busy;
  logic                 ovs_valid;
  logic [DATA_W-1:0]    ovs_data;
  logic [RAW_W-1:0]     ovs_raw;

  // Bus handshake
  logic                 wr_take;
  logic                 rd_take;

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a == OFF_CTRL) | (a == OFF_STAT) | (a == OFF_SEQ1) |
             (a == OFF_SEQ2) | (a == OFF_SEQ3) | (a == OFF_DATA) |
             (a == OFF_THR)  | (a == OFF_OVS);
  endfunction : mapped

  function automatic logic [CH_W-1:0] chan_at(input logic [CH_W*SEQ_N-1:0] all,
                                              input logic [LEN_W-1:0]      p);
    logic [CH_W-1:0] e;
    e = all[p*CH_W +: CH_W];
    // Entries past the last internal channel fold onto it
    chan_at = (e > CH_LAST) ? CH_LAST : e;
  endfunction : chan_at

  // Field decode
  wire                   en        = ctrl[CB_EN];
  wire [1:0]             res_code  = ctrl[CB_RES +: 2];
  wire [LEN_W-1:0]       seq_len   = seq_first[LEN_LSB +: LEN_W];
  wire [CH_W*SEQ_N-1:0]  seq_all   = {seq_first[LEN_LSB-1:0], seq_second, seq_third};
  wire [CH_W-1:0]        chan_next = chan_at(seq_all, next_pos);

  // Write decode
  wire        wr_ctrl  = wr_take & (s_axi_awaddr == OFF_CTRL);
  wire        wr_stat  = wr_take & (s_axi_awaddr == OFF_STAT);
  wire        wr_seq1  = wr_take & (s_axi_awaddr == OFF_SEQ1);
  wire        wr_seq2  = wr_take & (s_axi_awaddr == OFF_SEQ2);
  wire        wr_seq3  = wr_take & (s_axi_awaddr == OFF_SEQ3);
  wire        wr_thr   = wr_take & (s_axi_awaddr == OFF_THR);
  wire        wr_ovs   = wr_take & (s_axi_awaddr == OFF_OVS);
  wire [31:0] ctrl_v   = merge(32'(ctrl), s_axi_wdata, s_axi_wstrb);
  wire [31:0] seq1_v   = merge(32'(seq_first), s_axi_wdata, s_axi_wstrb);
  wire [31:0] seq2_v   = merge(32'(seq_second), s_axi_wdata, s_axi_wstrb);
  wire [31:0] seq3_v   = merge(32'(seq_third), s_axi_wdata, s_axi_wstrb);
  wire [31:0] thr_v    = merge({4'h0, thr_hi, 4'h0, thr_lo}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] ovs_v    = merge(32'(ovs_cfg), s_axi_wdata, s_axi_wstrb);
  wire        eoc_clr  = wr_stat & s_axi_wstrb[0] & ~s_axi_wdata[SB_EOC];
  wire        wd_clr   = wr_stat & s_axi_wstrb[0] & ~s_axi_wdata[SB_WD];

  // Read decode; calibration start reads back the running calibration
  wire [31:0] ctrl_rd  = {19'h0, ctrl[CTRL_W-1:2], cal_busy, ctrl[CB_EN]};
  wire [31:0] stat_rd  = {29'h0, (state != SQ_IDLE), wd_flag, eoc};
  wire [31:0] rd_word  =
    (s_axi_araddr == OFF_CTRL) ? ctrl_rd :
    (s_axi_araddr == OFF_STAT) ? stat_rd :
    (s_axi_araddr == OFF_SEQ1) ? 32'(seq_first) :
    (s_axi_araddr == OFF_SEQ2) ? 32'(seq_second) :
    (s_axi_araddr == OFF_SEQ3) ? 32'(seq_third) :
    (s_axi_araddr == OFF_DATA) ? 32'(result) :
    (s_axi_araddr == OFF_THR)  ? {4'h0, thr_hi, 4'h0, thr_lo} :
    (s_axi_araddr == OFF_OVS)  ? 32'(ovs_cfg) :
    32'h0;

  // Conversion start: software pulse or rising edge of the trigger input
  wire hw_edge   = ctrl[CB_HWTRIG] & hw_trigger & ~trig_q;
  wire start_req = en & ~cal_busy & (swst_p | hw_edge);
  wire last_pos  = ~ctrl[CB_SCAN] | (pos == seq_len);
  wire conv_in   = (state == SQ_WAIT) & ana_done;
  wire wd_hit    = ctrl[CB_WDEN] & ((ovs_raw > thr_hi) | (ovs_raw < thr_lo));

  acs_cal u_cal (
    .clk           (clk),
    .resetn        (resetn),
    .enable        (en),
    .start         (calst_p),
    .cal_reset     (calrst_p),
    .cal_done      (ana_cal_done),
    .cal_factor_in (ana_cal_factor),
    .busy          (cal_busy),
    .factor        (cal_factor)
  );

  acs_ovs u_ovs (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (~en | (state == SQ_IDLE)),
    .in_valid  (conv_in),
    .in_raw    (ana_data),
    .res_code  (res_code),
    .left      (ctrl[CB_LEFT]),
    .ovs_en    (ovs_cfg[OB_EN]),
    .ratio     (ovs_cfg[OB_RATIO +: 3]),
    .shift     (ovs_cfg[OB_SHIFT +: 4]),
    .out_valid (ovs_valid),
    .out_data  (ovs_data),
    .out_raw   (ovs_raw)
  );

  // Routine sequence walk
  always_comb begin
    next_state  = state;
    next_pos    = pos;
    next_sample = 1'b0;
    store       = 1'b0;
    eoc_set     = 1'b0;
    case (state)
      SQ_IDLE: begin
        if (start_req) begin
          next_pos    = '0;
          next_sample = 1'b1;
          next_state  = SQ_WAIT;
        end
      end
      SQ_WAIT: begin
        if (ana_done) begin
          next_state = SQ_NEXT;
        end
      end
      SQ_NEXT: begin
        next_sample = 1'b1;
        next_state  = SQ_WAIT;
        if (ovs_valid) begin
          store = 1'b1;
          if (!last_pos) begin
            next_pos = pos + 4'h1;
          end else begin
            eoc_set  = 1'b1;
            next_pos = '0;
            if (!ctrl[CB_CONT]) begin
              next_sample = 1'b0;
              next_state  = SQ_IDLE;
            end
          end
        end
      end
      default: begin
        next_state = SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= SQ_IDLE;
      pos        <= '0;
      ana_sample <= 1'b0;
      ana_chan   <= '0;
    end else if (!en) begin
      state      <= SQ_IDLE;
      pos        <= '0;
      ana_sample <= 1'b0;
    end else begin
      state      <= next_state;
      pos        <= next_pos;
      ana_sample <= next_sample;
      ana_chan   <= next_sample ? chan_next : ana_chan;
    end
  end

  // Result and event flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result  <= '0;
      eoc     <= 1'b0;
      wd_flag <= 1'b0;
    end else if (!en) begin
      result  <= '0;
      eoc     <= 1'b0;
      wd_flag <= 1'b0;
    end else begin
      result  <= store ? ovs_data : result;
      eoc     <= eoc_set | (eoc & ~eoc_clr);
      wd_flag <= (store & wd_hit) | (wd_flag & ~wd_clr);
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl       <= CTRL_RST;
      seq_first  <= '0;
      seq_second <= '0;
      seq_third  <= '0;
      thr_hi     <= THR_HI_RST;
      thr_lo     <= THR_LO_RST;
      ovs_cfg    <= '0;
    end else begin
      ctrl       <= wr_ctrl ? (ctrl_v[CTRL_W-1:0] & CTRL_MASK) : ctrl;
      seq_first  <= wr_seq1 ? seq1_v[FIRST_W-1:0] : seq_first;
      seq_second <= wr_seq2 ? seq2_v[SECOND_W-1:0] : seq_second;
      seq_third  <= wr_seq3 ? seq3_v[THIRD_W-1:0] : seq_third;
      thr_hi     <= wr_thr ? thr_v[THR_HI_LSB +: RAW_W] : thr_hi;
      thr_lo     <= wr_thr ? thr_v[RAW_W-1:0] : thr_lo;
      ovs_cfg    <= wr_ovs ? ovs_v[OVS_W-1:0] : ovs_cfg;
    end
  end

  // Self-clearing command bits become one-cycle pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      calst_p  <= 1'b0;
      calrst_p <= 1'b0;
      swst_p   <= 1'b0;
      trig_q   <= 1'b0;
    end else begin
      calst_p  <= wr_ctrl & ctrl_v[CB_CAL] & en;
      calrst_p <= wr_ctrl & ctrl_v[CB_CALRST];
      swst_p   <= wr_ctrl & ctrl_v[CB_SWST];
      trig_q   <= hw_trigger;
    end
  end

  // Analog side levels and interrupt lines
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ana_reset     <= 1'b1;
      ana_powerdown <= 1'b1;
      ana_res       <= 2'h0;
      ana_cal_req   <= 1'b0;
      eoc_irq       <= 1'b0;
      wd_irq        <= 1'b0;
    end else begin
      ana_reset     <= ~en;
      ana_powerdown <= ~en;
      ana_res       <= res_code;
      ana_cal_req   <= cal_busy & ~ana_cal_done;
      eoc_irq       <= eoc & ctrl[CB_EOCIE];
      wd_irq        <= wd_flag & ctrl[CB_WDIE];
    end
  end

  // AXI4-Lite write channel: address and data taken together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_take      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      wr_take      <= ~wr_take & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid;
      s_axi_bvalid <= wr_take | (s_axi_bvalid & ~s_axi_bready);
      if (wr_take) begin
        s_axi_bresp <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_take      <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      rd_take      <= ~rd_take & ~s_axi_rvalid & s_axi_arvalid;
      s_axi_rvalid <= rd_take | (s_axi_rvalid & ~s_axi_rready);
      if (rd_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
endmodule : acs_top
`default_nettype wire

//--- tb/acs_top_chk.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acs_top_chk
  import acs_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     ana_reset,
  input wire logic                     ana_powerdown,
  input wire logic                     ana_sample,
  input wire logic [acs_pkg::CH_W-1:0] ana_chan,
  input wire logic                     ana_cal_req,
  input wire logic                     ana_cal_done,
  input wire logic [acs_pkg::CF_W-1:0] cal_factor
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_cal_end;
    ana_cal_req && ana_cal_done;
  endsequence
  // Two cycles held; the factor flop clears on the same edge that raises ana_reset
  sequence s_held_off;
    ana_reset [*2];
  endsequence
  a_cal_clears: assert property (s_cal_end |-> ##[1:2] !ana_cal_req) else $error("calibration request stuck");
  a_factor_off: assert property (s_held_off |-> cal_factor == '0) else $error("factor kept while off");
  a_pd_match: assert property (ana_reset == ana_powerdown) else $error("power-down differs from reset");
  a_idle_off: assert property (ana_reset |-> !ana_sample && !ana_cal_req) else $error("activity while off");
  a_sample_pulse: assert property (ana_sample |=> !ana_sample) else $error("sample pulse too long");
  a_chan_range: assert property (ana_sample |-> ana_chan <= CH_LAST) else $error("channel out of range");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_pair: assert property (s_axi_awready |-> s_axi_wready ##1 (!s_axi_awready && s_axi_bvalid))
    else $error("write take malformed");
endmodule : acs_top_chk
bind acs_top acs_top_chk u_chk (.clk, .resetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ana_reset, .ana_powerdown, .ana_sample, .ana_chan,
  .ana_cal_req, .ana_cal_done, .cal_factor);
`default_nettype wire

//--- tb/acs_ana_model.sv
// Behavioural model of the analog converter and its calibration engine
`timescale 1ns/1ps
`default_nettype none
module acs_ana_model
  import acs_pkg::*;
#(
  parameter logic [acs_pkg::CF_W-1:0] CAL_F = 7'h5a
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      ana_sample,
  input  wire logic [acs_pkg::CH_W-1:0]  ana_chan,
  input  wire logic                      ana_cal_req,
  output logic                           ana_done,
  output logic [acs_pkg::RAW_W-1:0]      ana_data,
  output logic                           ana_cal_done,
  output logic [acs_pkg::CF_W-1:0]       ana_cal_factor
);
  logic [2:0]      cnt;
  logic [4:0]      ccnt;
  logic [CH_W-1:0] ch;
  logic            cal_go;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ana_done, ana_cal_done, cnt, ccnt, cal_go, ch} <= '0;
      ana_data <= 12'h5a5;
      ana_cal_factor <= 7'h0;
    end else begin
      ana_done <= 1'b0;
      ana_cal_done <= 1'b0;
      // Outside an answer the lines toggle, so stale values cannot pass
      ana_data <= ~ana_data;
      ana_cal_factor <= ~ana_cal_factor;
      if (ana_sample) begin
        ch <= ana_chan;
        cnt <= 3'(1 + $urandom % 5);
      end else if (cnt == 3'h1) begin
        ana_done <= 1'b1;
        ana_data <= {ch, 7'h2b};
        cnt <= 3'h0;
      end else if (cnt != 3'h0) cnt <= cnt - 3'h1;
      if (!ana_cal_req) cal_go <= 1'b0;
      else if (!cal_go) begin
        cal_go <= 1'b1;
        ccnt <= 5'h18;
      end else if (ccnt == 5'h1) begin
        ana_cal_done <= 1'b1;
        ana_cal_factor <= CAL_F;
        ccnt <= 5'h0;
      end else if (ccnt != 5'h0) ccnt <= ccnt - 5'h1;
    end
  end
endmodule : acs_ana_model
`default_nettype wire

//--- tb/acs_top_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acs_top_tb;
  import acs_pkg::*;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hw_trigger, ana_done, ana_cal_done;
  logic ana_reset, ana_powerdown, ana_sample, ana_cal_req, eoc_irq, wd_irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, sq;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ana_res, r;
  logic [11:0] ana_data;
  logic [4:0]  ana_chan, ch[6];
  logic [6:0]  ana_cal_factor, cal_factor;
  logic [4:0]  seen[$];
  int n_fail, tests_run, cyc, len, n;
  acs_top dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_trigger, .ana_done, .ana_data,
    .ana_cal_done, .ana_cal_factor, .ana_reset, .ana_powerdown, .ana_sample, .ana_chan, .ana_res, .ana_cal_req,
    .cal_factor, .eoc_irq, .wd_irq);
  acs_ana_model u_ana (.clk, .resetn, .ana_sample, .ana_chan, .ana_cal_req, .ana_done, .ana_data, .ana_cal_done,
    .ana_cal_factor);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (ana_sample) seen.push_back(ana_chan);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {v, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic [15:0] exp_d(input logic [4:0] c, input int k);
    exp_d = {4'h0, c, 7'h2b} >> (2 * k);
  endfunction : exp_d
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hw_trigger} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h8a808662));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("off", {ana_reset, ana_powerdown, cal_factor}, {2'b11, 7'h0});
    rd(OFF_CTRL, d, r);
    chk("ctrl_rst", d, 0);
    wr(OFF_CTRL, 32'h3, r);
    rd(OFF_CTRL, d, r);
    chk("ctrl_en", d, 1);
    chk("on", {ana_reset, ana_powerdown}, 0);
    repeat (14) @(posedge clk);
    wr(OFF_CTRL, 32'h7, r);
    rd(OFF_CTRL, d, r);
    chk("busy", d[1], 1);
    wr(OFF_CTRL, 32'h1, r);
    rd(OFF_CTRL, d, r);
    chk("busy_kept", d[1], 1);
    do rd(OFF_CTRL, d, r); while (d[1]);
    chk("factor", cal_factor, 7'h5a);
    for (int k = 0; k < 4; k++) begin
      len = $urandom % 6;
      sq = 0;
      for (int i = 0; i < 6; i++) begin
        ch[i] = 5'($urandom % 18);
        sq[5*i +: 5] = ch[i];
      end
      wr(OFF_SEQ1, 32'(len) << LEN_LSB, r);
      wr(OFF_SEQ3, sq, r);
      seen.delete();
      // Last pass runs single mode from the trigger pin at 6-bit resolution
      wr(OFF_CTRL, (k == 3 ? 32'h601 : 32'h419) | (32'(k) << CB_RES), r);
      if (k == 3) hw_trigger <= 1'b1;
      n = (k == 3) ? 0 : len;
      do rd(OFF_STAT, d, r); while (!d[0]);
      hw_trigger <= 1'b0;
      chk("irq", {eoc_irq, wd_irq, ana_res}, {2'b10, 2'(k)});
      chk("count", seen.size(), n + 1);
      for (int i = 0; i <= n && i < seen.size(); i++) chk("chan", seen[i], ch[i]);
      rd(OFF_DATA, d, r);
      chk("data", d[15:0], exp_d(ch[n], k));
      wr(OFF_STAT, 0, r);
      rd(OFF_STAT, d, r);
      chk("eoc_clr", d[0], 0);
      chk("factor_kept", cal_factor, 7'h5a);
    end
    wr(8'h40, 32'h1, r);
    chk("wr_unmap", r, RESP_SLVERR);
    rd(8'h40, d, r);
    chk("rd_unmap", {d, r}, {32'h0, RESP_SLVERR});
    wr(OFF_CTRL, 0, r);
    repeat (3) @(posedge clk);
    chk("off_again", {ana_reset, ana_powerdown, cal_factor}, {2'b11, 7'h0});
    stop_test();
  end
endmodule : acs_top_tb
`default_nettype wire
